// >>> design/adc_link_pkg.sv
// constants shared by both ends of the converter readout link
// assumes both ends run from one 250 MHz reference clock
package adc_link_pkg;
    // reference clock
    localparam int CLK_PERIOD_NS = 4;
    // result word and frame shape
    localparam int RESULT_W = 16;
    localparam int BURST_PULSES = 18;
    localparam int EXTRA_PULSES = 1;
    localparam int FRAME_SAMPLES = BURST_PULSES + EXTRA_PULSES;
    localparam logic [2:0] SYNC_HEADER = 3'h2;
    localparam logic [1:0] HEADER_TAIL = 2'h2;
    localparam logic FRAME_IDLE_BIT = 1'h0;
    // result-ready delay after a start edge, a least time
    localparam int T_MSB_NS = 100;
    localparam int T_MSB_CYC =
        (T_MSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // upper limit on the start pulse high time, a longest time
    localparam int START_PULSE_HIGH_LIMIT_NS = 20;
    localparam int START_PULSE_HIGH_CYC =
        (START_PULSE_HIGH_LIMIT_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (START_PULSE_HIGH_LIMIT_NS / CLK_PERIOD_NS);
    // extra host wait covering synchroniser latency on both ends
    localparam int LINK_MARGIN_CYC = 8;
    // host shift clock half period in reference cycles
    localparam int SCLK_HALF_CYC = 3;
    // number of capture phases
    localparam int CAPTURE_PHASES = 3;
endpackage : adc_link_pkg

// >>> design/adc_link_if.sv
// interface joining the converter end and the host end
// the three wires are the logical levels of the differential pairs
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
    logic conv_start_pair;
    logic shift_clk;
    logic serial_data;

    // converter end: no clock is returned with the data
    modport dev (
        input  conv_start_pair,
        input  shift_clk,
        output serial_data
    );

    // host end
    modport host (
        output conv_start_pair,
        output shift_clk,
        input  serial_data
    );
endinterface : adc_link_if
`default_nettype wire

// >>> design/adc_device_end.sv
// converter end: conversion start and self-clocked serial readout
// assumes start and shift clock arrive from outside this clock domain
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - start conversion on start rising edge
// - every result preceded by header 010
// - first header zero appears without clocks
// - header one, zero on first falls
// - later bits on successive shift falls
// - no clock returned with data
// - start pulse triggers a conversion
// - host returns start low in time
// - start pulses ignored while converting
// - host bursts after delay, before deadline
// - unread result replaced by newer one
// - host shift clock idles high
// - nineteenth pulse gives guaranteed zero
// - host samples on three phases
// - host picks phase by header one
// - shared clock, per-converter capture timing
module adc_device_end
    import adc_link_pkg::*;
#(
    parameter int CONV_CYC = T_MSB_CYC
) (
    // clock and reset
    input  wire logic                REF_CLK_IN,
    input  wire logic                RST_B_IN,
    // analog sample stand-in
    input  wire logic [RESULT_W-1:0] SAMPLE_IN,
    // status
    output logic                     CONV_BUSY_OUT,
    output logic                     START_IGNORED_OUT,
    output logic                     RESULT_LOST_OUT,
    output logic                     FRAME_DONE_OUT,
    // link
    adc_link_if.dev                  link
);

    typedef enum logic {
        CV_IDLE = 1'h0,
        CV_BUSY = 1'h1
    } conv_state_t;

    typedef enum logic [1:0] {
        FR_EMPTY = 2'h0,
        FR_READY = 2'h1,
        FR_SHIFT = 2'h2,
        FR_DONE  = 2'h3
    } frame_state_t;

    localparam int FRAME_W = RESULT_W + 2;
    localparam int CNT_W = $clog2(CONV_CYC + 1);
    localparam int FALL_W = $clog2(FRAME_SAMPLES + 1);
    localparam logic [FALL_W-1:0] LAST_FALL = FALL_W'(BURST_PULSES);

    if (CONV_CYC < 1) begin : g_chk_conv
        $error("conversion time must be at least one cycle");
    end

    // synchronisers for start and shift clock
    logic                    cnv_s1_q;
    logic                    cnv_s2_q;
    logic                    cnv_s3_q;
    logic                    sck_s1_q;
    logic                    sck_s2_q;
    logic                    sck_s3_q;
    logic                    cnv_rise;
    logic                    sck_fall;

    conv_state_t             conv_q;
    logic [CNT_W-1:0]        conv_cnt_q;
    logic [RESULT_W-1:0]     sample_q;
    logic                    conv_done;

    frame_state_t            frame_q;
    logic [FRAME_W-1:0]      frame_sh_q;
    logic [FALL_W-1:0]       fall_cnt_q;
    logic                    data_q;
    logic                    ignored_q;
    logic                    lost_q;
    logic                    done_q;

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            cnv_s1_q <= 1'h0;
            cnv_s2_q <= 1'h0;
            cnv_s3_q <= 1'h0;
        end else begin
            cnv_s1_q <= link.conv_start_pair;
            cnv_s2_q <= cnv_s1_q;
            cnv_s3_q <= cnv_s2_q;
        end
    end

    // idle level of the shift clock is high
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            sck_s1_q <= 1'h1;
            sck_s2_q <= 1'h1;
            sck_s3_q <= 1'h1;
        end else begin
            sck_s1_q <= link.shift_clk;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end

    assign cnv_rise = cnv_s2_q & ~cnv_s3_q;
    assign sck_fall = sck_s3_q & ~sck_s2_q;

    // conversion state
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            conv_q <= CV_IDLE;
            conv_cnt_q <= '0;
        end else begin
            unique case (conv_q)
                CV_IDLE: begin
                    if (cnv_rise) begin
                        conv_q <= CV_BUSY;
                        conv_cnt_q <= CNT_W'(CONV_CYC - 1);
                    end
                end
                CV_BUSY: begin
                    if (conv_cnt_q == '0) begin
                        conv_q <= CV_IDLE;
                    end else begin
                        conv_cnt_q <= conv_cnt_q - 1'h1;
                    end
                end
            endcase
        end
    end

    assign conv_done = (conv_q == CV_BUSY) && (conv_cnt_q == '0);

    // sample held at the start edge
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            sample_q <= '0;
        end else if (conv_q == CV_IDLE && cnv_rise) begin
            sample_q <= SAMPLE_IN;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            ignored_q <= 1'h0;
        end else begin
            ignored_q <= (conv_q == CV_BUSY) && cnv_rise;
        end
    end

    // frame shifter
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            frame_q <= FR_EMPTY;
            frame_sh_q <= '0;
            fall_cnt_q <= '0;
            data_q <= FRAME_IDLE_BIT;
        end else if (conv_done) begin
            frame_sh_q <= {HEADER_TAIL, sample_q};
            // first header bit shown at once
            data_q <= SYNC_HEADER[2];
            fall_cnt_q <= '0;
            frame_q <= FR_READY;
        end else if (sck_fall) begin
            data_q <= frame_sh_q[FRAME_W-1];
            frame_sh_q <= {frame_sh_q[FRAME_W-2:0], FRAME_IDLE_BIT};
            if (fall_cnt_q != LAST_FALL) begin
                fall_cnt_q <= fall_cnt_q + 1'h1;
            end
            if (fall_cnt_q == LAST_FALL - 1'h1) begin
                frame_q <= FR_DONE;
            end else if (frame_q == FR_READY) begin
                frame_q <= FR_SHIFT;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            lost_q <= 1'h0;
        end else begin
            lost_q <= conv_done &&
                      (frame_q == FR_READY || frame_q == FR_SHIFT);
        end
    end

    // frame complete report
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            done_q <= 1'h0;
        end else begin
            done_q <= sck_fall && !conv_done &&
                      (fall_cnt_q == LAST_FALL - 1'h1);
        end
    end

    // data pair only, no clock out
    assign link.serial_data = data_q;

    assign CONV_BUSY_OUT = (conv_q == CV_BUSY);
    assign START_IGNORED_OUT = ignored_q;
    assign RESULT_LOST_OUT = lost_q;
    assign FRAME_DONE_OUT = done_q;

endmodule : adc_device_end
`default_nettype wire

// >>> design/adc_host_end.sv
// host end: start pulses, shift clock bursts, phase-picking capture
// assumes one instance per converter; results leave through a FIFO
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             REF_CLK_IN,
    input  wire logic             RST_B_IN,
    // fill side
    input  wire logic             IN_VALID_IN,
    output logic                  IN_READY_OUT,
    input  wire logic [WIDTH-1:0] IN_DATA_IN,
    // drain side
    output logic                  OUT_VALID_OUT,
    input  wire logic             OUT_READY_IN,
    output logic [WIDTH-1:0]      OUT_DATA_OUT
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
        $error("fifo depth must be a power of two, at least two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign IN_READY_OUT = (cnt_q != (AW+1)'(DEPTH));
    assign OUT_VALID_OUT = (cnt_q != '0);
    assign push = IN_VALID_IN & IN_READY_OUT;
    assign pop = OUT_VALID_OUT & OUT_READY_IN;
    assign OUT_DATA_OUT = mem_q[rd_q];

    always_ff @(posedge REF_CLK_IN) begin
        if (push) begin
            mem_q[wr_q] <= IN_DATA_IN;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : result_fifo

module adc_host_end
    import adc_link_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int PULSES = FRAME_SAMPLES,
    parameter int WAIT_CYC = T_MSB_CYC + LINK_MARGIN_CYC,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic                REF_CLK_IN,
    input  wire logic                RST_B_IN,
    // conversion request
    input  wire logic                START_IN,
    output logic                     START_READY_OUT,
    // result stream
    output logic                     RESULT_VALID_OUT,
    input  wire logic                RESULT_READY_IN,
    output logic [RESULT_W-1:0]      RESULT_DATA_OUT,
    // capture status
    output logic [1:0]               PHASE_OUT,
    output logic                     SYNC_ERR_OUT,
    // link
    adc_link_if.host                 link
);
    localparam int PERIOD = 2 * HALF_CYC;
    localparam int PC_W = $clog2(PERIOD);
    localparam int K_W = $clog2(FRAME_SAMPLES + 1);
    localparam int T_W = $clog2(WAIT_CYC + START_PULSE_HIGH_CYC + 1);

    if (PERIOD % CAPTURE_PHASES != 0 || HALF_CYC < 3) begin : g_chk_p
        $error("shift period must split into three phases");
    end
    if (PULSES < BURST_PULSES || PULSES > FRAME_SAMPLES) begin : g_chk_n
        $error("burst must hold 18 or 19 pulses");
    end

    typedef enum logic [2:0] {
        H_IDLE  = 3'h0,
        H_CNV   = 3'h1,
        H_WAIT  = 3'h2,
        H_BURST = 3'h3,
        H_PICK  = 3'h4,
        H_PUSH  = 3'h5
    } host_state_t;

    host_state_t              st_q;
    logic [T_W-1:0]           tmr_q;
    logic [PC_W-1:0]          pc_q;
    logic [K_W-1:0]           k_q;
    logic                     cnv_q;
    logic                     sck_q;
    logic                     din_s1_q;
    logic                     din_s2_q;
    logic [FRAME_SAMPLES-1:0] cap_q [CAPTURE_PHASES];
    logic [RESULT_W-1:0]      word [CAPTURE_PHASES];
    logic [CAPTURE_PHASES-1:0] ok;
    logic [1:0]               sel;
    logic [RESULT_W-1:0]      res_q;
    logic [1:0]               phase_q;
    logic                     err_q;
    logic                     fifo_ready;
    logic                     period_end;

    // data pair synchroniser
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            din_s1_q <= 1'h0;
            din_s2_q <= 1'h0;
        end else begin
            din_s1_q <= link.serial_data;
            din_s2_q <= din_s1_q;
        end
    end

    assign period_end = (pc_q == PC_W'(PERIOD - 1));

    // sequencer
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            st_q <= H_IDLE;
            tmr_q <= '0;
            pc_q <= '0;
            k_q <= '0;
        end else begin
            unique case (st_q)
                H_IDLE: begin
                    if (START_IN) begin
                        st_q <= H_CNV;
                        tmr_q <= T_W'(START_PULSE_HIGH_CYC - 1);
                    end
                end
                H_CNV: begin
                    if (tmr_q == '0) begin
                        st_q <= H_WAIT;
                        tmr_q <= T_W'(WAIT_CYC - 1);
                    end else begin
                        tmr_q <= tmr_q - 1'h1;
                    end
                end
                H_WAIT: begin
                    // burst only after the ready delay
                    if (tmr_q == '0) begin
                        st_q <= H_BURST;
                        pc_q <= '0;
                        k_q <= '0;
                    end else begin
                        tmr_q <= tmr_q - 1'h1;
                    end
                end
                H_BURST: begin
                    pc_q <= period_end ? '0 : pc_q + 1'h1;
                    if (period_end) begin
                        k_q <= k_q + 1'h1;
                        if (k_q == K_W'(FRAME_SAMPLES - 1)) begin
                            st_q <= H_PICK;
                        end
                    end
                end
                H_PICK: begin
                    st_q <= H_PUSH;
                end
                H_PUSH: begin
                    // stalls while the fifo is full and the frame had no sync error
                    if (fifo_ready || err_q) begin
                        st_q <= H_IDLE;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    // start pulse dropped within the limit
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            cnv_q <= 1'h0;
        end else begin
            cnv_q <= (st_q == H_CNV) && (tmr_q != '0);
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            sck_q <= 1'h1;
        end else begin
            sck_q <= !((st_q == H_BURST) && (k_q < K_W'(PULSES)) &&
                       (pc_q < PC_W'(HALF_CYC)));
        end
    end

    // three capture phases 120 degrees apart
    for (genvar p = 0; p < CAPTURE_PHASES; p++) begin : g_phase
        always_ff @(posedge REF_CLK_IN) begin
            if (!RST_B_IN || st_q == H_WAIT) begin
                cap_q[p] <= '0;
            end else if (st_q == H_BURST &&
                         pc_q == PC_W'(p * PERIOD / CAPTURE_PHASES)) begin
                cap_q[p] <= {cap_q[p][FRAME_SAMPLES-2:0], din_s2_q};
            end
        end
        always_comb begin
            ok[p] = 1'h0;
            word[p] = '0;
            if (cap_q[p][FRAME_SAMPLES-1 -: 3] == SYNC_HEADER) begin
                ok[p] = 1'h1;
                word[p] = cap_q[p][RESULT_W-1:0];
            end else if (cap_q[p][FRAME_SAMPLES-1 -: 2] == HEADER_TAIL) begin
                ok[p] = 1'h1;
                word[p] = cap_q[p][RESULT_W:1];
            end
        end
    end

    always_comb begin
        if (ok[1]) begin
            sel = 2'h1;
        end else if (ok[2]) begin
            sel = 2'h2;
        end else begin
            sel = 2'h0;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            res_q <= '0;
            phase_q <= '0;
            err_q <= 1'h0;
        end else if (st_q == H_PICK) begin
            res_q <= word[sel];
            phase_q <= sel;
            err_q <= (ok == '0);
        end
    end

    result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .REF_CLK_IN   (REF_CLK_IN),
        .RST_B_IN     (RST_B_IN),
        .IN_VALID_IN  ((st_q == H_PUSH) && !err_q),
        .IN_READY_OUT (fifo_ready),
        .IN_DATA_IN   (res_q),
        .OUT_VALID_OUT(RESULT_VALID_OUT),
        .OUT_READY_IN (RESULT_READY_IN),
        .OUT_DATA_OUT (RESULT_DATA_OUT)
    );

    assign link.conv_start_pair = cnv_q;
    assign link.shift_clk = sck_q;
    assign START_READY_OUT = (st_q == H_IDLE);
    assign PHASE_OUT = phase_q;
    assign SYNC_ERR_OUT = err_q;

endmodule : adc_host_end
`default_nettype wire

// >>> dv/adc_link_sva.sv
// checker on the link wires between the host end and the converter end
// assumes one reference clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module adc_link_sva
    import adc_link_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // link wires
    input wire logic conv_start_pair,
    input wire logic shift_clk,
    input wire logic serial_data
);
    localparam int LOW_BY = START_PULSE_HIGH_CYC - 1;
    logic [4:0] falls_q;
    logic [7:0] since_q;
    logic       sclk_q;
    logic       conv_q;
    logic       seen_q;

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    // previous levels of the wires
    always_ff @(posedge REF_CLK_IN) begin
        sclk_q <= RST_B_IN ? shift_clk : 1'h1;
        conv_q <= RST_B_IN ? conv_start_pair : 1'h0;
        seen_q <= RST_B_IN && (seen_q || conv_start_pair);
    end

    // shift falls since the last start rise
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN || (conv_start_pair && !conv_q)) begin
            falls_q <= '0;
        end else if (sclk_q && !shift_clk && falls_q != 5'h1f) begin
            falls_q <= falls_q + 5'h01;
        end
    end

    // cycles since the last start rise
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN || (conv_start_pair && !conv_q)) begin
            since_q <= '0;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
        end
    end

    a_start_short: assert property (
        $rose(conv_start_pair) |->
            conv_start_pair[*2] ##[1:LOW_BY] !conv_start_pair)
        else $error("start pulse width wrong");
    a_idle_high: assert property (
        conv_start_pair |-> shift_clk)
        else $error("shift clock low during start pulse");
    a_burst_late: assert property (
        $fell(shift_clk) |-> since_q >= T_MSB_CYC)
        else $error("shift burst before result ready");
    a_head_zero: assert property (
        $fell(shift_clk) && falls_q == 5'h00 |-> !serial_data)
        else $error("first header bit not zero");
    a_head_one: assert property (
        $fell(shift_clk) && falls_q == 5'h01 |-> serial_data)
        else $error("second header bit not one");
    a_head_tail: assert property (
        $fell(shift_clk) && falls_q == 5'h02 |-> !serial_data)
        else $error("third header bit not zero");
    a_low_width: assert property (
        $fell(shift_clk) |-> !shift_clk[*3] ##1 shift_clk)
        else $error("shift clock low phase wrong");
    a_last_zero: assert property (
        $rose(shift_clk) && falls_q == 5'h13 |-> ##3 !serial_data)
        else $error("extra pulse did not give zero");
    a_whole_burst: assert property (
        $rose(conv_start_pair) && seen_q |-> falls_q == 5'h13)
        else $error("burst incomplete before next start");
    a_quiet_data: assert property (
        conv_start_pair |-> !serial_data)
        else $error("data not zero between frames");

    c_start: cover property ($rose(conv_start_pair));
    c_header: cover property ($fell(shift_clk) && falls_q == 5'h02);
    c_full: cover property ($rose(shift_clk) && falls_q == 5'h13);
endmodule : adc_link_sva
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench: host end against converter end, plus a second
// converter end whose link the bench drives by hand to break the rules
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adc_link_pkg::*;
    typedef struct {
        logic [15:0] val;
        logic [15:0] exp;
    } row_t;

    logic                clk;
    logic                rst_b;
    logic                start;
    logic                ready;
    logic [RESULT_W-1:0] sample;
    logic [RESULT_W-1:0] sample2;
    logic                start_rdy;
    logic                res_valid;
    logic [RESULT_W-1:0] res_data;
    logic [1:0]          phase;
    logic                sync_err;
    logic [1:0]          busy;
    logic [1:0]          ign;
    logic [1:0]          lost;
    logic [1:0]          done;
    logic [19:0]         bits;
    int                  bad_count;
    int                  compares;
    int                  ign_n;
    int                  lost_n;
    int                  done_n;
    int                  done_a;
    int                  fault_a;
    row_t                rows [6];

    adc_link_if link_a ();
    adc_link_if link_b ();

    adc_device_end adc_device_end_i (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
        .SAMPLE_IN(sample), .CONV_BUSY_OUT(busy[0]),
        .START_IGNORED_OUT(ign[0]), .RESULT_LOST_OUT(lost[0]),
        .FRAME_DONE_OUT(done[0]), .link(link_a.dev));
    adc_device_end adc_device_end_i2 (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
        .SAMPLE_IN(sample2), .CONV_BUSY_OUT(busy[1]),
        .START_IGNORED_OUT(ign[1]), .RESULT_LOST_OUT(lost[1]),
        .FRAME_DONE_OUT(done[1]), .link(link_b.dev));
    adc_host_end adc_host_end_i (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
        .START_IN(start), .START_READY_OUT(start_rdy),
        .RESULT_VALID_OUT(res_valid), .RESULT_READY_IN(ready),
        .RESULT_DATA_OUT(res_data), .PHASE_OUT(phase),
        .SYNC_ERR_OUT(sync_err), .link(link_a.host));
    adc_link_sva adc_link_sva_i (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
        .conv_start_pair(link_a.conv_start_pair),
        .shift_clk(link_a.shift_clk), .serial_data(link_a.serial_data));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // status pulses of the hand-driven converter and of the host-driven converter
    always @(posedge clk) begin
        ign_n += (ign[1] === 1'h1);
        lost_n += (lost[1] === 1'h1);
        done_n += (done[1] === 1'h1);
        done_a += (done[0] === 1'h1);
        fault_a += (ign[0] === 1'h1) + (lost[0] === 1'h1);
    end

    task automatic check(input string name, input logic [19:0] seen,
                         input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic convert(input logic [15:0] val);
        int n;
        n = 0;
        while (start_rdy !== 1'h1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("start ready", start_rdy, 1'h1);
        sample = val;
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
    endtask : convert

    task automatic pop(input logic [15:0] exp);
        int n;
        n = 0;
        while (res_valid !== 1'h1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("valid", res_valid, 1'h1);
        check("result", res_data, exp);
        check("sync error", sync_err, 1'h0);
        check("phase", phase, 2'h1);
        ready = 1'h1;
        @(negedge clk);
        ready = 1'h0;
    endtask : pop

    task automatic pulse_b();
        @(negedge clk);
        link_b.conv_start_pair = 1'h1;
        repeat (2) @(negedge clk);
        link_b.conv_start_pair = 1'h0;
    endtask : pulse_b

    // shift clock of 160 ns made by the bench
    task automatic burst(input int n, output logic [19:0] got);
        got = '0;
        got[19] = link_b.serial_data;
        for (int i = 1; i <= n; i++) begin
            link_b.shift_clk = 1'h0;
            repeat (10) @(negedge clk);
            got[19-i] = link_b.serial_data;
            repeat (10) @(negedge clk);
            link_b.shift_clk = 1'h1;
            repeat (20) @(negedge clk);
        end
    endtask : burst

    initial begin
        #200000;
        bad_count++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        rst_b = 1'h0;
        start = 1'h0;
        ready = 1'h0;
        sample = '0;
        sample2 = '0;
        link_b.conv_start_pair = 1'h0;
        link_b.shift_clk = 1'h1;
        rows = '{'{16'h0000, 16'h0000}, '{16'hffff, 16'hffff},
                 '{16'ha5a5, 16'ha5a5}, '{16'h8001, 16'h8001},
                 '{16'h7ffe, 16'h7ffe}, '{16'h0001, 16'h0001}};
        repeat (16) @(negedge clk);
        rst_b = 1'h1;
        foreach (rows[i]) begin
            convert(rows[i].val);
            pop(rows[i].exp);
        end
        check("host frames", 20'(done_a), 20'h6);
        check("host faults", 20'(fault_a), 20'h0);
        $display("test rows done");
        for (int i = 0; i < 9; i++) begin
            convert(16'h1000 + 16'(i));
        end
        repeat (300) @(negedge clk);
        check("start ready when full", start_rdy, 1'h0);
        for (int i = 0; i < 9; i++) begin
            pop(16'h1000 + 16'(i));
        end
        @(negedge clk);
        check("valid when empty", res_valid, 1'h0);
        $display("test fifo done");
        sample2 = 16'h3c5a;
        pulse_b();
        repeat (8) @(negedge clk);
        check("busy", busy[1], 1'h1);
        sample2 = 16'hffff;
        pulse_b();
        repeat (40) @(negedge clk);
        check("ignored", 20'(ign_n), 20'h1);
        check("busy after", busy[1], 1'h0);
        burst(19, bits);
        check("frame", bits, {1'h0, 2'h2, 16'h3c5a, 1'h0});
        $display("test ignored start done");
        sample2 = 16'h1234;
        pulse_b();
        repeat (40) @(negedge clk);
        burst(5, bits);
        sample2 = 16'h9abc;
        pulse_b();
        repeat (40) @(negedge clk);
        check("lost", 20'(lost_n), 20'h1);
        burst(19, bits);
        check("newer frame", bits, {1'h0, 2'h2, 16'h9abc, 1'h0});
        check("frames done", 20'(done_n), 20'h2);
        $display("test missed read done");
        convert(16'h5555);
        repeat (80) @(negedge clk);
        rst_b = 1'h0;
        repeat (16) @(negedge clk);
        check("reset start", link_a.conv_start_pair, 1'h0);
        check("reset shift", link_a.shift_clk, 1'h1);
        check("reset data", link_a.serial_data, 1'h0);
        check("reset busy", busy[0], 1'h0);
        check("reset valid", res_valid, 1'h0);
        rst_b = 1'h1;
        @(negedge clk);
        check("ready after reset", start_rdy, 1'h1);
        convert(16'h5a5a);
        pop(16'h5a5a);
        $display("test reset done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
